// *** design/mlc_loop_config.v ***
// Notes on behaviour
// R1: modulation bit zero selects continuous, one selects discontinuous space vector modulation.
// R2: window field: 0 open and closed loop, 1 closed only, 2 first-try open, 3 invalid.
// R3: divider field divides speed pulses; codes 0 and 1 divide by one, fifteen maximum.
// R4: stop-config zero: pulse while driven; one: pulse until back-emf falls below threshold.
// R5: threshold codes 0..5 give 1,2,5,10,20,30 mV symmetric; codes 6 and 7 invalid.
// R6: surge guard bit turns anti-surge protection off at zero, on at one.
// R7: deadband correction bit turns deadtime compensation off at zero, on at one.
// R8: velocity loop bit inverted: zero keeps speed loop running, one disables it.
// R9: recirculation stop during align or open loop: tri-state at zero, low-side brake at one.
// R10: second tuning register sits at index 8Ah and resets to all zeros.
// R11: second register layout: parity 31, stop fields, resistance 15:8, inductance 7:0.
// R12: stop method codes: tri-state, recirculation, low, high, spin-down, align braking.
`timescale 1ns/1ps
`include "mlc_map.vh"
module mlc_loop_config #(
   parameter ADDR_W = 12
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]        s_axi_awprot,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output wire [1:0]        s_axi_bresp,
   output wire              s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]        s_axi_arprot,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output wire [31:0]       s_axi_rdata,
   output wire [1:0]        s_axi_rresp,
   output wire              s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire [1:0]        motor_phase,
   input  wire              first_try,
   input  wire              rotor_event,
   input  wire [7:0]        emf_abs_mv,
   input  wire              stop_request,
   output wire              speed_pulse_output,
   output wire              modulation_discontinuous,
   output wire              anti_surge_protection,
   output wire              deadband_comp_enable,
   output wire              velocity_loop_enable,
   output wire [2:0]        stop_action,
   output wire              stop_active,
   output wire [3:0]        stop_brake_duration,
   output wire [3:0]        active_spin_down_limit,
   output wire [3:0]        brake_speed_threshold,
   output wire [7:0]        winding_resistance,
   output wire [7:0]        winding_inductance,
   output wire              tuning_parity
);

   // byte-lane merge of write data into an old value
   function [31:0] lane_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  strb;
      integer i;
      begin
         lane_merge = old_val;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
            end
         end
      end
   endfunction

   // word index from a byte address, zero when misaligned, bit 8 set when out of range
   function [8:0] word_index;
      input [ADDR_W-1:0] addr;
      begin
         if (addr[1:0] != 2'b00) begin
            word_index = 9'h000;
         end else begin
            word_index = {1'b0, addr[9:2]} | {addr[ADDR_W-1:10] != 0, 8'h00};
         end
      end
   endfunction

   // threshold lookup in millivolts, zero for the invalid codes
   function [7:0] emf_threshold_mv;
      input [2:0] code;
      begin
         case (code)
            3'h0:    emf_threshold_mv = `MLC_THR_MV0;
            3'h1:    emf_threshold_mv = `MLC_THR_MV1;
            3'h2:    emf_threshold_mv = `MLC_THR_MV2;
            3'h3:    emf_threshold_mv = `MLC_THR_MV3;
            3'h4:    emf_threshold_mv = `MLC_THR_MV4;
            3'h5:    emf_threshold_mv = `MLC_THR_MV5;
            default: emf_threshold_mv = 8'h00;
         endcase
      end
   endfunction

   reg  [31:0]       tune1_reg;
   reg  [31:0]       tune2_reg;
   reg               aw_held_reg;
   reg  [ADDR_W-1:0] aw_addr_reg;
   reg               w_held_reg;
   reg  [31:0]       w_data_reg;
   reg  [3:0]        w_strb_reg;
   reg               bvalid_reg;
   reg  [1:0]        bresp_reg;
   reg               rvalid_reg;
   reg  [31:0]       rdata_reg;
   reg  [1:0]        rresp_reg;
   reg               pulse_run_reg;
   reg               pulse_out_reg;
   reg  [3:0]        pulse_cnt_reg;
   reg  [2:0]        stop_action_reg;
   reg               stop_active_reg;

   wire [1:0] win_sel;
   wire [3:0] div_code;
   wire [3:0] div_n;
   wire       stop_cfg;
   wire [2:0] thr_code;
   wire [2:0] stop_method;
   wire       window_open;
   wire       driven;
   wire       emf_below;
   wire       win_invalid;
   wire       thr_invalid;
   wire       stop_invalid;
   wire       wr_fire;
   wire [8:0] wr_idx;
   wire [8:0] rd_idx;
   wire [31:0] status_word;

   // field views of the first tuning register and the stop method of the second
   assign win_sel     = tune1_reg[`MLC_T1_WIN_HI:`MLC_T1_WIN_LO];
   assign div_code    = tune1_reg[`MLC_T1_DIV_HI:`MLC_T1_DIV_LO];
   assign stop_cfg    = tune1_reg[`MLC_T1_STOPCFG_BIT];
   assign thr_code    = tune1_reg[`MLC_T1_THR_HI:`MLC_T1_THR_LO];
   assign stop_method = tune2_reg[`MLC_T2_STOP_HI:`MLC_T2_STOP_LO];
   assign div_n       = (div_code < 4'h2) ? 4'h1 : div_code; // R3
   assign win_invalid  = (win_sel == 2'h3); // R2
   assign thr_invalid  = (thr_code > 3'h5); // R5
   assign stop_invalid = (stop_method > 3'h5); // R12

   // static control outputs
   assign modulation_discontinuous = tune1_reg[`MLC_T1_MOD_BIT]; // R1
   assign anti_surge_protection    = tune1_reg[`MLC_T1_SURGE_BIT]; // R6
   assign deadband_comp_enable     = tune1_reg[`MLC_T1_DEADBAND_BIT]; // R7
   assign velocity_loop_enable     = ~tune1_reg[`MLC_T1_VLOOP_OFF_BIT]; // R8

   // second tuning register fields
   assign tuning_parity          = tune2_reg[`MLC_T2_PARITY_BIT]; // R11
   assign stop_brake_duration    = tune2_reg[`MLC_T2_BRKTIME_HI:`MLC_T2_BRKTIME_LO]; // R11
   assign active_spin_down_limit = tune2_reg[`MLC_T2_SPIN_HI:`MLC_T2_SPIN_LO]; // R11
   assign brake_speed_threshold  = tune2_reg[`MLC_T2_BRKSPD_HI:`MLC_T2_BRKSPD_LO]; // R11
   assign winding_resistance     = tune2_reg[`MLC_T2_RES_HI:`MLC_T2_RES_LO]; // R11
   assign winding_inductance     = tune2_reg[`MLC_T2_IND_HI:`MLC_T2_IND_LO]; // R11

   // speed pulse window by loop state
   assign driven = (motor_phase != `MLC_PH_IDLE);
   assign window_open =
      (win_sel == `MLC_WIN_ALWAYS)     ? (motor_phase == `MLC_PH_OPEN) || (motor_phase == `MLC_PH_CLOSED) :
      (win_sel == `MLC_WIN_CLOSED)     ? (motor_phase == `MLC_PH_CLOSED) :
      (win_sel == `MLC_WIN_FIRST_OPEN) ? (motor_phase == `MLC_PH_CLOSED) ||
                                         ((motor_phase == `MLC_PH_OPEN) && first_try) :
      1'b0; // R2

   // invalid threshold code never counts as below, the pulse keeps going
   assign emf_below = !thr_invalid && (emf_abs_mv < emf_threshold_mv(thr_code)); // R5

   // speed pulse run state and divided square wave
   always @(posedge aclk) begin
      if (!aresetn) begin
         pulse_run_reg <= 1'b0;
         pulse_out_reg <= 1'b0;
         pulse_cnt_reg <= 4'h0;
      end else begin
         if (driven && window_open) begin
            pulse_run_reg <= 1'b1;
         end else if (driven || !stop_cfg || emf_below) begin
            pulse_run_reg <= 1'b0; // R4
         end
         if (!pulse_run_reg) begin
            pulse_out_reg <= 1'b0;
            pulse_cnt_reg <= 4'h0;
         end else if (rotor_event) begin
            if (pulse_cnt_reg + 4'h1 >= div_n) begin
               pulse_cnt_reg <= 4'h0;
               pulse_out_reg <= ~pulse_out_reg; // R3
            end else begin
               pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
            end
         end
      end
   end

   assign speed_pulse_output = pulse_out_reg;

   // stop action chosen from stop method and loop state
   always @(posedge aclk) begin
      if (!aresetn) begin
         stop_action_reg <= `MLC_STOP_TRISTATE;
         stop_active_reg <= 1'b0;
      end else begin
         stop_active_reg <= stop_request;
         if (stop_invalid) begin
            stop_action_reg <= `MLC_STOP_TRISTATE;
         end else if ((stop_method == `MLC_STOP_RECIRC) &&
                      ((motor_phase == `MLC_PH_ALIGN) || (motor_phase == `MLC_PH_OPEN))) begin
            stop_action_reg <= tune1_reg[`MLC_T1_SLOWBRK_BIT] ? `MLC_STOP_LOW_BRAKE
                                                              : `MLC_STOP_TRISTATE; // R9
         end else begin
            stop_action_reg <= stop_method; // R12
         end
      end
   end

   assign stop_action = stop_action_reg;
   assign stop_active = stop_active_reg;

   // status word: live state of the block
   assign status_word = {25'h0, stop_invalid, thr_invalid, win_invalid,
                         emf_below, window_open, pulse_run_reg, pulse_out_reg};

   // write channel: address and data held independently
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_idx  = word_index(aw_addr_reg);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= {ADDR_W{1'b0}};
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `MLC_RESP_OKAY;
         tune1_reg   <= `MLC_TUNE1_RST;
         tune2_reg   <= `MLC_TUNE2_RST; // R10
      end else begin
         if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= `MLC_RESP_OKAY;
            if (wr_idx == {1'b0, `MLC_IDX_TUNE1}) begin
               tune1_reg <= lane_merge(tune1_reg, w_data_reg, w_strb_reg) & `MLC_T1_MASK;
            end else if (wr_idx == {1'b0, `MLC_IDX_TUNE2}) begin
               tune2_reg <= lane_merge(tune2_reg, w_data_reg, w_strb_reg); // R10
            end else if (wr_idx != {1'b0, `MLC_IDX_STATUS}) begin
               bresp_reg <= `MLC_RESP_SLVERR;
            end
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // read channel: one read at a time, data one cycle after the address
   assign s_axi_arready = !rvalid_reg;
   assign rd_idx = word_index(s_axi_araddr);

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= `MLC_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `MLC_RESP_OKAY;
            if (rd_idx == {1'b0, `MLC_IDX_TUNE1}) begin
               rdata_reg <= tune1_reg;
            end else if (rd_idx == {1'b0, `MLC_IDX_TUNE2}) begin
               rdata_reg <= tune2_reg; // R11
            end else if (rd_idx == {1'b0, `MLC_IDX_STATUS}) begin
               rdata_reg <= status_word;
            end else begin
               rdata_reg <= 32'h00000000;
               rresp_reg <= `MLC_RESP_SLVERR;
            end
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

endmodule

// *** design/mlc_map.vh ***
`ifndef MLC_MAP_VH
`define MLC_MAP_VH
// register indices, byte address is four times the index
`define MLC_IDX_TUNE1        8'h89
`define MLC_IDX_TUNE2        8'h8a
`define MLC_IDX_STATUS       8'h8b
// reset values
`define MLC_TUNE1_RST        32'h00000000
`define MLC_TUNE2_RST        32'h00000000
// first tuning register, writable bits 14..0
`define MLC_T1_MASK          32'h00007fff
`define MLC_T1_MOD_BIT       14
`define MLC_T1_WIN_HI        13
`define MLC_T1_WIN_LO        12
`define MLC_T1_DIV_HI        11
`define MLC_T1_DIV_LO        8
`define MLC_T1_STOPCFG_BIT   7
`define MLC_T1_THR_HI        6
`define MLC_T1_THR_LO        4
`define MLC_T1_SURGE_BIT     3
`define MLC_T1_DEADBAND_BIT  2
`define MLC_T1_VLOOP_OFF_BIT 1
`define MLC_T1_SLOWBRK_BIT   0
// second tuning register
`define MLC_T2_PARITY_BIT    31
`define MLC_T2_STOP_HI       30
`define MLC_T2_STOP_LO       28
`define MLC_T2_BRKTIME_HI    27
`define MLC_T2_BRKTIME_LO    24
`define MLC_T2_SPIN_HI       23
`define MLC_T2_SPIN_LO       20
`define MLC_T2_BRKSPD_HI     19
`define MLC_T2_BRKSPD_LO     16
`define MLC_T2_RES_HI        15
`define MLC_T2_RES_LO        8
`define MLC_T2_IND_HI        7
`define MLC_T2_IND_LO        0
// speed pulse window codes
`define MLC_WIN_ALWAYS       2'h0
`define MLC_WIN_CLOSED       2'h1
`define MLC_WIN_FIRST_OPEN   2'h2
// stop methods
`define MLC_STOP_TRISTATE    3'h0
`define MLC_STOP_RECIRC      3'h1
`define MLC_STOP_LOW_BRAKE   3'h2
// motor phases
`define MLC_PH_IDLE          2'h0
`define MLC_PH_ALIGN         2'h1
`define MLC_PH_OPEN          2'h2
`define MLC_PH_CLOSED        2'h3
// emf thresholds in millivolts
`define MLC_THR_MV0          8'h01
`define MLC_THR_MV1          8'h02
`define MLC_THR_MV2          8'h05
`define MLC_THR_MV3          8'h0a
`define MLC_THR_MV4          8'h14
`define MLC_THR_MV5          8'h1e
// axi responses
`define MLC_RESP_OKAY        2'h0
`define MLC_RESP_SLVERR      2'h2
`endif

// *** testbench/mlc_checker.sv ***
`timescale 1ns/1ps
module mlc_checker (
   input logic        aclk,
   input logic        aresetn,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic [31:0] s_axi_rdata,
   input logic        rotor_event,
   input logic        speed_pulse_output,
   input logic        stop_request,
   input logic        stop_active,
   input logic        velocity_loop_enable,
   input logic [2:0]  stop_action,
   input logic [7:0]  winding_inductance
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // read answers come one edge after the request, write answers two edges after; both hold until taken
   // both halves are held for one cycle before the write is performed
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   a_write_ready_back: assert property ($rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
      else $error("write channels not free after write");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_arready_busy: assert property (s_axi_arready != s_axi_rvalid)
      else $error("read address ready wrong");
   // reset state of outputs
   a_reset_state: assert property (disable iff (1'b0) !aresetn |=> velocity_loop_enable && !s_axi_bvalid &&
      !s_axi_rvalid && stop_action == 3'h0 && !speed_pulse_output && winding_inductance == 8'h00)
      else $error("reset state wrong");
   // configuration outputs move only with a performed write
   a_loop_moves: assert property ($changed(velocity_loop_enable) |-> $rose(s_axi_bvalid))
      else $error("loop enable moved without write");
   a_field_moves: assert property ($changed(winding_inductance) |-> $rose(s_axi_bvalid))
      else $error("tuning field moved without write");
   // pulse rising edges are caused by a rotor event
   a_pulse_cause: assert property ($rose(speed_pulse_output) |-> $past(rotor_event))
      else $error("pulse rose without event");
   a_stop_follow: assert property (1'b1 |=> stop_active == $past(stop_request))
      else $error("stop flag not one cycle late");
endmodule
bind mlc_loop_config mlc_checker i_chk (.*);

// *** testbench/test_motor_loop_config_fields.sv ***
`timescale 1ns/1ps
`include "mlc_map.vh"
module test_motor_loop_config_fields;
   logic        aclk = 1'b0, aresetn = 1'b0, first_try = 1'b0, rotor_event = 1'b0, stop_request = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [1:0]  motor_phase = 2'h0;
   logic [7:0]  emf_abs_mv = 8'h00;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, speed_pulse_output;
   logic        modulation_discontinuous, anti_surge_protection, deadband_comp_enable, velocity_loop_enable;
   logic        stop_active, tuning_parity;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, q, wd;
   logic [2:0]  stop_action, e;
   logic [3:0]  stop_brake_duration, active_spin_down_limit, brake_speed_threshold;
   logic [7:0]  winding_resistance, winding_inductance;
   logic [1:0]  r;
   logic [31:0] m [2];
   int          num_errors = 0, n_tests = 0, i, b, cnt, n;
   int          thr [6] = '{1, 2, 5, 10, 20, 30}; // emf thresholds in millivolts
   logic        p, op;

   mlc_loop_config i_dut (.*);

   // clock generator
   always #12.5 aclk = ~aclk;

   task automatic complete_run;
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one bus access, write when w is high; returns read data and response
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int  k;
      logic hit, ta, tw, tr;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (k = 0; k < 40; k++) begin
         @(negedge aclk);
         hit = w ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         r = w ? s_axi_bresp : s_axi_rresp;
         ta = s_axi_awready;
         tw = s_axi_wready;
         tr = s_axi_arready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
         if (hit) break;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      // let one edge pass so the next request never re-raises a ready in this time step
      @(posedge aclk);
      if (k == 40) begin
         num_errors++;
         complete_run();
      end
   endtask

   initial begin
      void'($urandom(46));
      emf_abs_mv <= 8'($urandom);
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      m[0] = `MLC_TUNE1_RST;
      m[1] = `MLC_TUNE2_RST;
      bus(0, 12'h228, 0, 0); check(q, m[1]);
      // random writes with byte enables, read back and field outputs
      for (i = 0; i < 12; i++) begin
         wd = $urandom;
         n = (i < 4) ? 15 : $urandom % 16;
         bus(1, i[0] ? 12'h228 : 12'h224, wd, 4'(n)); check(r, `MLC_RESP_OKAY);
         for (b = 0; b < 4; b++) if (n[b]) m[i[0]][8*b+:8] = wd[8*b+:8];
         m[0] = m[0] & `MLC_T1_MASK;
         bus(0, i[0] ? 12'h228 : 12'h224, 0, 0); check(q, m[i[0]]);
         check({modulation_discontinuous, anti_surge_protection, deadband_comp_enable, velocity_loop_enable},
                {m[0][14], m[0][3], m[0][2], !m[0][1]});
         check({tuning_parity, stop_brake_duration, active_spin_down_limit, brake_speed_threshold,
                winding_resistance, winding_inductance}, {m[1][31], m[1][27:0]});
      end
      // unmapped place is refused
      bus(1, 12'h800, 32'hffffffff, 4'hf); check(r, `MLC_RESP_SLVERR);
      bus(0, 12'h800, 0, 0);
      check(q, 32'h0);
      check(r, `MLC_RESP_SLVERR);
      // every stop code and brake choice, in closed, open and align phases
      for (i = 0; i < 64; i++) begin
         motor_phase <= i[4] ? (i[5] ? `MLC_PH_ALIGN : `MLC_PH_OPEN) : `MLC_PH_CLOSED;
         stop_request <= i[0];
         bus(1, 12'h224, {31'h0, i[3]}, 4'hf);
         bus(1, 12'h228, {1'b0, i[2:0], 28'h0}, 4'hf);
         e = (i[2:0] > 5) ? `MLC_STOP_TRISTATE : i[2:0];
         if (e == `MLC_STOP_RECIRC && i[4]) e = i[3] ? `MLC_STOP_LOW_BRAKE : `MLC_STOP_TRISTATE;
         repeat (2) @(posedge aclk);
         check(stop_action, e);
         // status shows the stop code as invalid only for codes six and seven
         bus(0, 12'h22c, 0, 0);
         check(q[6:4], {i[2:0] > 5, 2'b00});
      end
      // speed pulse window and divider, counted over thirty events
      for (i = 0; i < 16; i++) begin
         motor_phase <= `MLC_PH_IDLE;
         bus(1, 12'h224, {18'h0, i[1:0], 4'(15 - i), 8'h00}, 4'hf);
         repeat (2) @(posedge aclk);
         check(speed_pulse_output, 1'b0);
         op = !i[2];
         motor_phase <= op ? `MLC_PH_OPEN : `MLC_PH_CLOSED;
         first_try <= i[3];
         repeat (3) @(posedge aclk);
         cnt = 0;
         p = speed_pulse_output;
         repeat (30) begin
            rotor_event <= 1'b1;
            @(posedge aclk);
            rotor_event <= 1'b0;
            @(posedge aclk);
            if (speed_pulse_output !== p) cnt++;
            p = speed_pulse_output;
         end
         n = (15 - i < 2) ? 1 : 15 - i;
         b = (i[1:0] == 0) || (i[1:0] == 1 && !op) || (i[1:0] == 2 && (!op || i[3]));
         check(cnt, b ? 30 / n : 0);
      end
      // stop-config one: pulse run outlives the drive until emf falls below threshold
      for (i = 0; i < 16; i++) begin
         n = $urandom % 40;
         emf_abs_mv <= 8'(n);
         motor_phase <= `MLC_PH_CLOSED;
         bus(1, 12'h224, {24'h0, 1'b1, i[2:0], 4'h0}, 4'hf);
         motor_phase <= `MLC_PH_IDLE;
         repeat (2) @(posedge aclk);
         bus(0, 12'h22c, 0, 0);
         b = (i[2:0] > 5) ? 1 : (n >= thr[i[2:0]]);
         check(q[1], b);
      end
      complete_run();
   end
endmodule
